// >>> shared/sepcmd_pkg.sv
// constants for the serial eeprom command and protection block
// assumes a 50 MHz system clock sampling a slower host serial clock
package sepcmd_pkg;
  // opcodes
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;
  // status register field positions
  localparam int SR_BUSY = 0;
  localparam int SR_WRITE_LATCH = 1;
  localparam int SR_GUARD_LO = 2;
  localparam int SR_GUARD_HI = 3;
  localparam int SR_PAGE_LOCK = 4;
  localparam int SR_ZERO = 5;
  localparam int SR_PAGE_SELECT = 6;
  localparam int SR_PIN_ENABLE = 7;
  // protected range bottoms (14-bit array addresses)
  localparam logic [13:0] GUARD_QUARTER_BASE = 14'h3000;
  localparam logic [13:0] GUARD_HALF_BASE = 14'h2000;
  localparam logic [13:0] GUARD_FULL_BASE = 14'h0000;
  // sizes
  localparam int ADDR_BITS = 14;
  localparam int PAGE_BITS = 6;
  localparam int PAGE_BYTES = 64;
  localparam int FIFO_DEPTH = 32;
  // self-timed write time in microseconds, and its length in clock cycles
  localparam int CLK_MHZ = 50;
  localparam int SELF_TIMED_WRITE_TIME_US = 5000;
  localparam int SELF_TIMED_WRITE_CYCLES = SELF_TIMED_WRITE_TIME_US * CLK_MHZ;
  // command decoder states
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_WRDATA, ST_RDDATA, ST_STATUS_OUT, ST_STATUS_IN, ST_IGNORE
  } sepcmd_state_t;
endpackage

// >>> verilog/sepcmd_sync.sv
// two-flop synchroniser for one level from outside the clock domain
// assumes the input is asynchronous to clk_in
`timescale 1ns/10ps
module sepcmd_sync (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic d_in,
  input wire logic rst_val_in,
  output logic q_out
);
  logic meta_r;
  // ----------------------------------------------------------------
  // capture chain
  // ----------------------------------------------------------------
  // only the second stage is ever read downstream
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      meta_r <= rst_val_in;
      q_out <= rst_val_in;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule

// >>> verilog/sepcmd_fifo.sv
// write-data FIFO holding page bytes until programming starts
// assumes a single clock; valid/ready on both sides
`timescale 1ns/10ps
module sepcmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic flush_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_r != '0);
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;
  assign rd_data_out = mem[rp_r];
  // storage has no reset, pointers do
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_r] <= wr_data_in;
    end
  end
  // pointer and count bookkeeping; flush empties the queue
  always_ff @(posedge clk_in) begin
    if (!nrst_in || flush_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> verilog/sepcmd_core.sv
// command decoder, status register and write protection of a serial eeprom
// assumes SPI pins arrive asynchronously and the host clock is far below CLK_IN
`timescale 1ns/10ps
module sepcmd_core
  import sepcmd_pkg::*;
#(
  parameter int WRITE_CYCLES = SELF_TIMED_WRITE_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CS_N_IN,
  input wire logic SCK_IN,
  input wire logic SI_IN,
  input wire logic WP_N_IN,
  input wire logic HOLD_N_IN,
  output logic SO_OUT,
  output logic SO_OE_OUT,
  output logic PROG_VALID_OUT,
  output logic PROG_PAGE_OUT,
  output logic [ADDR_BITS-1:0] PROG_ADDR_OUT,
  output logic [7:0] PROG_DATA_OUT,
  output logic RD_REQ_OUT,
  output logic RD_PAGE_OUT,
  output logic [ADDR_BITS-1:0] RD_ADDR_OUT,
  input wire logic [7:0] RD_DATA_IN,
  output logic [7:0] STATUS_OUT
);
  import sepcmd_pkg::*;

  logic cs_n_s, sck_s, si_s, wp_n_s, hold_n_s;
  logic sck_d_r;
  logic cs_d_r;
  logic paused_r;
  logic rise, fall, cs_fall, cs_rise;
  sepcmd_state_t state_r;
  logic [7:0] shift_r;
  logic [2:0] bitcnt_r;
  logic [4:0] addrcnt_r;
  logic [15:0] addr_r;
  logic [7:0] out_r;
  logic rd_take_r;
  logic [7:0] opcode_r;
  logic latch_pending_r;
  logic [7:0] sr_wr_r;
  logic sr_wr_ok_r;
  logic mem_ok_r;
  logic latch_r, guard_lo_r, guard_hi_r, lock_r, page_sel_r, pin_en_r;
  logic busy_r;
  logic [31:0] timer_r;
  logic [ADDR_BITS-1:0] prog_addr_r;
  logic prog_page_r;
  logic [6:0] nbytes_r;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [7:0] byte_in;
  logic hw_protect;
  logic [13:0] guard_base;
  logic guard_any;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sepcmd_sync u_cs (.clk_in(CLK_IN), .nrst_in(NRST_IN), .d_in(CS_N_IN),
    .rst_val_in(1'b1), .q_out(cs_n_s));
  sepcmd_sync u_sck (.clk_in(CLK_IN), .nrst_in(NRST_IN), .d_in(SCK_IN),
    .rst_val_in(1'b0), .q_out(sck_s));
  sepcmd_sync u_si (.clk_in(CLK_IN), .nrst_in(NRST_IN), .d_in(SI_IN),
    .rst_val_in(1'b0), .q_out(si_s));
  sepcmd_sync u_wp (.clk_in(CLK_IN), .nrst_in(NRST_IN), .d_in(WP_N_IN),
    .rst_val_in(1'b1), .q_out(wp_n_s));
  sepcmd_sync u_hold (.clk_in(CLK_IN), .nrst_in(NRST_IN), .d_in(HOLD_N_IN),
    .rst_val_in(1'b1), .q_out(hold_n_s));

  // edge history of the synchronised serial clock and select pins
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      sck_d_r <= 1'b0; // idle level of the clock, so no false edge follows reset
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_n_s;
    end
  end

  // pause on hold
  // hold is sampled only while the serial clock is low
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN || cs_n_s) begin
      paused_r <= 1'b0;
    end else if (!sck_s) begin
      paused_r <= !hold_n_s;
    end
  end

  assign rise = sck_s && !sck_d_r && !cs_n_s && !paused_r;
  assign fall = !sck_s && sck_d_r && !cs_n_s && !paused_r;
  assign cs_fall = !cs_n_s && cs_d_r;
  assign cs_rise = cs_n_s && !cs_d_r;
  assign byte_in = {shift_r[6:0], si_s};

  // ----------------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------------
  // pin protection
  assign hw_protect = pin_en_r && !wp_n_s;
  assign guard_any = guard_lo_r || guard_hi_r;
  always_comb begin
    unique case ({guard_hi_r, guard_lo_r})
      2'b01: guard_base = GUARD_QUARTER_BASE;
      2'b10: guard_base = GUARD_HALF_BASE;
      default: guard_base = GUARD_FULL_BASE;
    endcase
  end

  // ----------------------------------------------------------------
  // serial command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN || cs_n_s) begin
      state_r <= ST_OPCODE;
      shift_r <= 8'h00;
      bitcnt_r <= 3'h0;
      addrcnt_r <= 5'h00;
      opcode_r <= 8'h00;
    end else if (rise) begin
      shift_r <= byte_in;
      bitcnt_r <= bitcnt_r + 3'h1;
      if (bitcnt_r == 3'h7) begin
        unique case (state_r)
          ST_OPCODE: begin
            opcode_r <= byte_in;
            if (byte_in == OP_STATUS_READ) begin
              state_r <= ST_STATUS_OUT;
            end else if (busy_r) begin
              state_r <= ST_IGNORE;
            end else if (byte_in == OP_STATUS_WRITE) begin
              state_r <= ST_STATUS_IN;
            end else if (byte_in == OP_MEM_READ || byte_in == OP_MEM_WRITE) begin
              state_r <= ST_ADDR;
            end else begin
              state_r <= ST_IGNORE;
            end
          end
          ST_ADDR: begin
            addrcnt_r <= addrcnt_r + 5'h1;
            if (addrcnt_r == 5'h1) begin
              state_r <= (opcode_r == OP_MEM_READ) ? ST_RDDATA : ST_WRDATA;
            end
          end
          ST_STATUS_IN: state_r <= ST_IGNORE;
          default: state_r <= state_r;
        endcase
      end
    end
  end

  // address register; reads advance through the whole array, or wrap inside the page when page select is set
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      addr_r <= 16'h0000;
    end else if (rise && state_r == ST_ADDR) begin
      addr_r <= {addr_r[14:0], si_s};
    end else if (rise && state_r == ST_RDDATA && bitcnt_r == 3'h7) begin
      addr_r <= addr_r + 16'h0001;
    end
  end

  // read data request toward the array, one per byte
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      RD_REQ_OUT <= 1'b0;
      RD_ADDR_OUT <= '0;
      RD_PAGE_OUT <= 1'b0;
    end else begin
      RD_REQ_OUT <= rise && bitcnt_r == 3'h7 &&
        (state_r == ST_RDDATA || (state_r == ST_ADDR && addrcnt_r == 5'h1));
      RD_PAGE_OUT <= page_sel_r;
      RD_ADDR_OUT <= page_sel_r ? {8'h00, byte_in[5:0]} : {addr_r[12:7], byte_in};
      if (state_r == ST_RDDATA) begin
        // fetch ahead: the byte after the one now shifting out
        RD_ADDR_OUT <= page_sel_r ? {8'h00, addr_r[5:0] + 6'h01} : addr_r[13:0] + 14'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  // tristate when deselected
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      out_r <= 8'h00;
      rd_take_r <= 1'b0;
      SO_OUT <= 1'b0;
      SO_OE_OUT <= 1'b0;
    end else begin
      SO_OE_OUT <= !cs_n_s && !paused_r &&
        (state_r == ST_STATUS_OUT || state_r == ST_RDDATA);
      // array answers in the cycle after the request
      rd_take_r <= RD_REQ_OUT;
      if (rd_take_r) begin
        out_r <= RD_DATA_IN;
      end else if (rise && bitcnt_r == 3'h7 && state_r == ST_OPCODE) begin
        out_r <= STATUS_OUT;
      end else if (fall && bitcnt_r == 3'h0 && state_r == ST_STATUS_OUT) begin
        out_r <= STATUS_OUT;
      end
      if (fall) begin
        SO_OUT <= (bitcnt_r == 3'h0) ? out_r[7] : out_r[3'h7 - bitcnt_r];
      end
    end
  end

  // ----------------------------------------------------------------
  // status register and write permission
  // ----------------------------------------------------------------
  // pending latch
  // set latch only counts if select rises straight after the opcode
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN || cs_fall) begin
      latch_pending_r <= 1'b0;
    end else if (rise) begin
      latch_pending_r <= bitcnt_r == 3'h7 && state_r == ST_OPCODE &&
        byte_in == OP_SET_WRITE_LATCH && !busy_r;
    end
  end

  // capture status data byte and its permission at the eighth bit
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN || cs_fall) begin
      sr_wr_r <= 8'h00;
      sr_wr_ok_r <= 1'b0;
    end else if (rise && state_r == ST_STATUS_IN && bitcnt_r == 3'h7) begin
      sr_wr_r <= byte_in;
      sr_wr_ok_r <= latch_r && !hw_protect;
    end else if (rise && state_r == ST_IGNORE) begin
      sr_wr_ok_r <= 1'b0; // extra bits spoil the sequence
    end else if (hw_protect) begin
      sr_wr_ok_r <= 1'b0; // pin low mid-frame interrupts the write
    end
  end

  always_comb begin
    STATUS_OUT = 8'h00;
    STATUS_OUT[SR_PIN_ENABLE] = pin_en_r;
    STATUS_OUT[SR_PAGE_SELECT] = page_sel_r;
    STATUS_OUT[SR_ZERO] = 1'b0;
    STATUS_OUT[SR_PAGE_LOCK] = lock_r;
    STATUS_OUT[SR_GUARD_HI] = guard_hi_r;
    STATUS_OUT[SR_GUARD_LO] = guard_lo_r;
    STATUS_OUT[SR_WRITE_LATCH] = latch_r;
    STATUS_OUT[SR_BUSY] = busy_r;
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      latch_r <= 1'b0;
    end else if (busy_r && timer_r == 32'h1) begin
      latch_r <= 1'b0;
    end else if (cs_rise && latch_pending_r) begin
      latch_r <= 1'b1;
    end else if (rise && bitcnt_r == 3'h7 && state_r == ST_OPCODE &&
                 byte_in == OP_CLEAR_WRITE_LATCH && !busy_r) begin
      latch_r <= 1'b0;
    end
  end

  // status bits loaded by a status write; busy is never host-writable
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      pin_en_r <= 1'b0;
      guard_hi_r <= 1'b0;
      guard_lo_r <= 1'b0;
      lock_r <= 1'b0;
      page_sel_r <= 1'b0;
    end else if (cs_rise && sr_wr_ok_r && state_r == ST_IGNORE &&
                 bitcnt_r == 3'h0 && opcode_r == OP_STATUS_WRITE) begin
      pin_en_r <= sr_wr_r[SR_PIN_ENABLE];
      guard_hi_r <= sr_wr_r[SR_GUARD_HI];
      guard_lo_r <= sr_wr_r[SR_GUARD_LO];
      if (!(sr_wr_r[SR_PAGE_SELECT] && sr_wr_r[SR_PAGE_LOCK])) begin
        lock_r <= lock_r || sr_wr_r[SR_PAGE_LOCK];
        page_sel_r <= sr_wr_r[SR_PAGE_SELECT];
      end
    end else if (cs_rise && (opcode_r == OP_MEM_READ || opcode_r == OP_MEM_WRITE) &&
                 state_r != ST_ADDR && state_r != ST_OPCODE) begin
      page_sel_r <= 1'b0;
    end
  end

  // locked page
  // permission for the memory write, judged on the first data byte address
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN || cs_fall) begin
      mem_ok_r <= 1'b0;
    end else if (rise && state_r == ST_ADDR && addrcnt_r == 5'h1 && bitcnt_r == 3'h7) begin
      mem_ok_r <= latch_r && (page_sel_r ?
        (!lock_r && !(guard_hi_r && guard_lo_r) &&
         !(guard_any && {8'h00, byte_in[5:0]} >= guard_base)) :
        !(guard_any && {addr_r[12:7], byte_in} >= guard_base));
    end else if (rise && state_r == ST_WRDATA && bitcnt_r != 3'h7) begin
      mem_ok_r <= mem_ok_r;
    end else if (rise && state_r == ST_WRDATA && bitcnt_r == 3'h7 && !fifo_in_ready) begin
      mem_ok_r <= 1'b0; // page buffer overflow spoils the write
    end else if (hw_protect && !latch_r) begin
      mem_ok_r <= 1'b0;
    end
  end

  assign fifo_in_valid = rise && state_r == ST_WRDATA && bitcnt_r == 3'h7 && mem_ok_r;
  assign fifo_out_ready = busy_r && PROG_VALID_OUT == 1'b0;

  // count bytes accepted into the page buffer for the write
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN || cs_fall) begin
      nbytes_r <= 7'h00;
    end else if (fifo_in_valid && fifo_in_ready) begin
      nbytes_r <= nbytes_r + 7'h01;
    end
  end

  sepcmd_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .flush_in(cs_fall && !busy_r),
    .wr_data_in(byte_in),
    .wr_valid_in(fifo_in_valid),
    .wr_ready_out(fifo_in_ready),
    .rd_data_out(fifo_out_data),
    .rd_valid_out(fifo_out_valid),
    .rd_ready_in(fifo_out_ready)
  );

  // ----------------------------------------------------------------
  // self-timed write
  // ----------------------------------------------------------------
  // start on select rise
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      busy_r <= 1'b0;
      timer_r <= 32'h0;
    end else if (!busy_r && cs_rise &&
                 ((opcode_r == OP_MEM_WRITE && mem_ok_r && nbytes_r != 7'h00 &&
                   bitcnt_r == 3'h0) ||
                  (opcode_r == OP_STATUS_WRITE && sr_wr_ok_r && bitcnt_r == 3'h0 &&
                   state_r == ST_IGNORE))) begin
      busy_r <= 1'b1;
      timer_r <= 32'(WRITE_CYCLES);
    end else if (busy_r) begin
      timer_r <= timer_r - 32'h1;
      if (timer_r == 32'h1) begin
        busy_r <= 1'b0;
      end
    end
  end

  // drain buffered bytes to the array with wrapped page addresses
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      PROG_VALID_OUT <= 1'b0;
      PROG_PAGE_OUT <= 1'b0;
      PROG_ADDR_OUT <= '0;
      PROG_DATA_OUT <= 8'h00;
      prog_addr_r <= '0;
      prog_page_r <= 1'b0;
    end else begin
      PROG_VALID_OUT <= fifo_out_valid && fifo_out_ready;
      PROG_DATA_OUT <= fifo_out_data;
      PROG_ADDR_OUT <= prog_addr_r;
      PROG_PAGE_OUT <= prog_page_r;
      if (cs_rise && !busy_r) begin
        prog_addr_r <= addr_r[13:0];
        prog_page_r <= page_sel_r;
      end else if (PROG_VALID_OUT) begin
        prog_addr_r <= {prog_addr_r[13:6], prog_addr_r[5:0] + 6'h01};
      end
    end
  end
endmodule

// >>> sim/sepcmd_asserts.sv
// pin-level checks on the command and protection core
// assumes binding to sepcmd_core; sees only its ports
`timescale 1ns/10ps
module sepcmd_asserts #(
  parameter int WRITE_CYCLES = 1500
) (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CS_N_IN,
  input wire logic SCK_IN,
  input wire logic SI_IN,
  input wire logic WP_N_IN,
  input wire logic HOLD_N_IN,
  input wire logic SO_OUT,
  input wire logic SO_OE_OUT,
  input wire logic PROG_VALID_OUT,
  input wire logic PROG_PAGE_OUT,
  input wire logic [sepcmd_pkg::ADDR_BITS-1:0] PROG_ADDR_OUT,
  input wire logic [7:0] PROG_DATA_OUT,
  input wire logic RD_REQ_OUT,
  input wire logic RD_PAGE_OUT,
  input wire logic [sepcmd_pkg::ADDR_BITS-1:0] RD_ADDR_OUT,
  input wire logic [7:0] RD_DATA_IN,
  input wire logic [7:0] STATUS_OUT
);
  import sepcmd_pkg::*;
  // -------
  // helpers
  // -------
  localparam int BUSY_MIN = WRITE_CYCLES - 4;
  localparam int BUSY_MAX = WRITE_CYCLES + 40;
  logic sck_r;
  logic [3:0] fall_age_r;
  int busy_len_r;
  // cycles since the raw serial clock fell, saturating
  always_ff @(posedge CLK_IN) begin
    sck_r <= SCK_IN;
    if (!NRST_IN || (sck_r && !SCK_IN)) fall_age_r <= 4'h0;
    else if (fall_age_r != 4'hf) fall_age_r <= fall_age_r + 4'h1;
  end
  // length of the current busy stretch
  always_ff @(posedge CLK_IN) begin
    if (STATUS_OUT[SR_BUSY]) busy_len_r <= busy_len_r + 1;
    else busy_len_r <= 0;
  end
  // a byte may never land in a guarded block or a locked page
  function automatic logic refused(logic pg, logic [13:0] a, logic [7:0] s);
    case (s[3:2])
      2'h1: refused = !pg && a >= GUARD_QUARTER_BASE;
      2'h2: refused = !pg && a >= GUARD_HALF_BASE;
      2'h3: refused = 1'b1;
      default: refused = 1'b0;
    endcase
    refused = refused || (pg && s[SR_PAGE_LOCK]);
  endfunction
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  sequence s_write_over;
    $fell(STATUS_OUT[SR_BUSY]);
  endsequence
  sequence s_busy_start;
    $rose(STATUS_OUT[SR_BUSY]);
  endsequence
  a_idle_no_drive: assert property (CS_N_IN [*5] |-> !SO_OE_OUT)
    else $error("serial output driven while deselected");
  a_so_on_fall: assert property (
    SO_OE_OUT && $past(SO_OE_OUT) && $changed(SO_OUT) |-> fall_age_r <= 4'h6)
    else $error("serial output moved away from a falling clock");
  a_zero_bit: assert property (STATUS_OUT[SR_ZERO] == 1'b0)
    else $error("status bit five not zero");
  a_prog_after_cs: assert property (
    PROG_VALID_OUT |-> CS_N_IN && $past(CS_N_IN, 2))
    else $error("programming before select rose");
  a_guard_range: assert property (
    PROG_VALID_OUT |-> !refused(PROG_PAGE_OUT, PROG_ADDR_OUT, STATUS_OUT))
    else $error("programmed a protected location");
  a_busy_length: assert property (
    s_write_over |-> busy_len_r >= BUSY_MIN && busy_len_r <= BUSY_MAX)
    else $error("busy stretch of wrong length");
  a_latch_cleared: assert property (
    s_write_over |-> ##[0:2] !STATUS_OUT[SR_WRITE_LATCH])
    else $error("write latch kept after write cycle");
  a_latch_needed: assert property (
    s_busy_start |-> $past(STATUS_OUT[SR_WRITE_LATCH]))
    else $error("write cycle without write latch");
  a_pin_freeze: assert property (
    $past(STATUS_OUT[SR_PIN_ENABLE] && !WP_N_IN && !STATUS_OUT[SR_BUSY]) && !WP_N_IN
    |-> $stable({STATUS_OUT[7], STATUS_OUT[4:2]}))
    else $error("status changed under pin protection");
endmodule
bind sepcmd_core sepcmd_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_asserts (
  .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CS_N_IN(CS_N_IN), .SCK_IN(SCK_IN), .SI_IN(SI_IN),
  .WP_N_IN(WP_N_IN), .HOLD_N_IN(HOLD_N_IN), .SO_OUT(SO_OUT), .SO_OE_OUT(SO_OE_OUT),
  .PROG_VALID_OUT(PROG_VALID_OUT), .PROG_PAGE_OUT(PROG_PAGE_OUT),
  .PROG_ADDR_OUT(PROG_ADDR_OUT), .PROG_DATA_OUT(PROG_DATA_OUT), .RD_REQ_OUT(RD_REQ_OUT),
  .RD_PAGE_OUT(RD_PAGE_OUT), .RD_ADDR_OUT(RD_ADDR_OUT), .RD_DATA_IN(RD_DATA_IN),
  .STATUS_OUT(STATUS_OUT));

// >>> sim/sepcmd_host.sv
// host serial controller model, mode (0,0)
// assumes the bench clock paces it; half clock period is 8 cycles
`timescale 1ns/10ps
module sepcmd_host (
  input wire logic clk_in,
  input wire logic so_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out,
  output logic hold_n_out
);
  localparam int HALF = 8;
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    hold_n_out = 1'b1;
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic sel();
    tick(1);
    cs_n_out <= 1'b0;
    tick(HALF);
  endtask
  // frame closes with select rising; released line shows no stale bit
  task automatic desel();
    tick(HALF);
    cs_n_out <= 1'b1;
    si_out <= ~si_out;
    tick(2 * HALF);
  endtask
  // msb first, optional pause with the clock low
  task automatic xfer(logic [7:0] tx, bit pause, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_out <= tx[i];
      if (pause && i == 4) begin
        tick(HALF);
        hold_n_out <= 1'b0;
        tick(4 * HALF);
        hold_n_out <= 1'b1;
      end
      tick(HALF);
      sck_out <= 1'b1;
      rx[i] = so_in;
      tick(HALF);
      sck_out <= 1'b0;
    end
  endtask
endmodule

// >>> sim/spi_eeprom_command_protect_tb.sv
// self-checking bench for the command and protection core
// assumes the host model drives pins and a pattern answers reads
`timescale 1ns/10ps
module spi_eeprom_command_protect_tb;
  import sepcmd_pkg::*;
  logic clk = 0;
  logic nrst = 0;
  logic wp_n = 1;
  logic cs_n, sck, si, hold_n, so, oe, pv, pp, rq, rp;
  logic [13:0] pa, ra;
  logic [7:0] pd, st;
  logic [7:0] rd = 8'h00;
  logic [7:0] rx[$];
  logic [22:0] got[$], want[$];
  int lat, gd, pe, ps, lk, bz, mismatches, checked;
  always #10 clk = ~clk;
  // array answers the cycle after a request
  always @(posedge clk) if (rq) rd <= ra[7:0] ^ {7'h0, rp} ^ 8'h5a;
  always @(posedge clk) if (pv) got.push_back({pp, pp ? 8'h00 : pa[13:6], pa[5:0], pd});
  sepcmd_core #(.WRITE_CYCLES(1500)) dut (.CLK_IN(clk), .NRST_IN(nrst), .CS_N_IN(cs_n),
    .SCK_IN(sck), .SI_IN(si), .WP_N_IN(wp_n), .HOLD_N_IN(hold_n), .SO_OUT(so),
    .SO_OE_OUT(oe), .PROG_VALID_OUT(pv), .PROG_PAGE_OUT(pp), .PROG_ADDR_OUT(pa),
    .PROG_DATA_OUT(pd), .RD_REQ_OUT(rq), .RD_PAGE_OUT(rp), .RD_ADDR_OUT(ra),
    .RD_DATA_IN(rd), .STATUS_OUT(st));
  sepcmd_host host (.clk_in(clk), .so_in(so), .cs_n_out(cs_n), .sck_out(sck),
    .si_out(si), .hold_n_out(hold_n));
  task automatic complete_run();
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string n, logic [22:0] s, logic [22:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] est();
    return {pe[0], ps[0], 1'b0, lk[0], gd[1:0], lat[0], bz[0]};
  endfunction
  // bounded wait for the write cycle to end
  task automatic idle();
    int n = 0;
    repeat (8) @(posedge clk);
    while (st[SR_BUSY] !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n == 2000) mismatches++;
    if (n == 2000) complete_run();
    repeat (4) @(posedge clk);
    bz = 0;
  endtask
  // one framed transfer, then the model's view of its effect
  task automatic frame(logic [7:0] q[$], int hp = 9);
    logic [7:0] r;
    logic [13:0] a;
    bit ok;
    rx = {};
    host.sel();
    foreach (q[i]) begin
      host.xfer(q[i], i == hp, r);
      rx.push_back(r);
    end
    host.desel();
    if (bz && q[0] != OP_STATUS_READ) return;
    case (q[0])
      OP_SET_WRITE_LATCH: lat |= (q.size() == 1);
      OP_CLEAR_WRITE_LATCH: lat = 0;
      OP_STATUS_WRITE: if (lat && !(pe && !wp_n)) begin
        if (!(q[1][6] && q[1][4])) begin
          ps = q[1][6];
          lk |= q[1][4];
        end
        pe = q[1][7];
        gd = q[1][3:2];
        lat = 0;
        bz = 1;
      end
      OP_MEM_WRITE, OP_MEM_READ: begin
        a = {q[1][5:0], q[2]};
        ok = ps ? !lk && gd != 3 : !(gd == 3 || gd == 2 && a[13] || gd == 1 && &a[13:12]);
        for (int i = 3; q[0] == OP_MEM_WRITE && lat && ok && i < q.size(); i++) begin
          want.push_back({ps[0], ps ? 8'h00 : a[13:6], a[5:0] + 6'(i - 3), q[i]});
          bz = 1;
        end
        ps = 0;
        if (bz) lat = 0;
      end
      default: ;
    endcase
  endtask
  task automatic cmp();
    idle();
    chk("status", st, est());
    chk("count", got.size(), want.size());
    while (got.size() > 0 && want.size() > 0) chk("prog", got.pop_front(), want.pop_front());
    got = {};
    want = {};
  endtask
  task automatic wr_status(logic [7:0] v);
    frame('{OP_SET_WRITE_LATCH});
    frame('{OP_STATUS_WRITE, v});
    cmp();
  endtask
  initial begin
    logic [7:0] q[$];
    void'($urandom(20));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk("reset", {oe, st}, 23'h0);
    frame('{OP_MEM_WRITE, 8'h00, 8'h10, 8'h55});
    cmp();
    frame('{OP_SET_WRITE_LATCH, 8'h00});
    cmp();
    frame('{OP_SET_WRITE_LATCH});
    cmp();
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    lat = 0;
    chk("reset2", {oe, st}, 23'h0);
    frame('{OP_SET_WRITE_LATCH});
    repeat (3) begin
      frame('{8'h08 | 8'($urandom), 8'h00});
      cmp();
    end
    frame('{OP_STATUS_READ, 8'h00});
    chk("status_read_cmd", rx[1], est());
    frame('{OP_CLEAR_WRITE_LATCH});
    cmp();
    wr_status(8'h84);
    wp_n <= 1'b0;
    wr_status(8'h00);
    wp_n <= 1'b1;
    frame('{OP_STATUS_WRITE, 8'h04});
    cmp();
    q = '{OP_MEM_WRITE, 8'hcf, 8'hfe};
    repeat (3) q.push_back(8'($urandom));
    frame('{OP_SET_WRITE_LATCH});
    frame(q);
    frame('{OP_STATUS_READ, 8'h00});
    chk("busy", rx[1][0], 1'b1);
    frame('{OP_STATUS_WRITE, 8'h8c});
    cmp();
    q = '{OP_MEM_WRITE, 8'h00, 8'h30};
    repeat (FIFO_DEPTH) q.push_back(8'($urandom));
    frame('{OP_SET_WRITE_LATCH});
    frame(q);
    cmp();
    frame('{OP_MEM_READ, 8'h12, 8'h34, 8'h00, 8'h00}, 1);
    chk("rd0", rx[3], 8'h6e);
    chk("rd1", rx[4], 8'h6f);
    for (int g = 0; g < 4; g++) begin
      wr_status(8'(g << 2));
      frame('{OP_SET_WRITE_LATCH});
      frame('{OP_MEM_WRITE, 8'h2f, 8'hff, 8'(g)});
      frame('{OP_CLEAR_WRITE_LATCH});
      cmp();
    end
    wr_status(8'h44);
    frame('{OP_MEM_READ, 8'h00, 8'h05, 8'h00});
    chk("idrd", rx[3], 8'h5e);
    for (int k = 0; k < 2; k++) begin
      wr_status(8'h44);
      frame('{OP_SET_WRITE_LATCH});
      frame('{OP_MEM_WRITE, 8'h00, 8'h07, 8'h3c});
      frame('{OP_CLEAR_WRITE_LATCH});
      cmp();
      wr_status(k == 0 ? 8'h54 : 8'h00);
      wr_status(8'h14);
    end
    complete_run();
  end
endmodule
